// [inc/ibc_consts.svh]
/*
  Constants for the two-wire master baud counter and stop collision block:
  APB offsets, register field positions, reset values, mode codes, timing.
  Assumes it is included by bare name from the stop and collision design file only.
*/
`ifndef IBC_CONSTS_SVH
`define IBC_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define IBC_OFF_RELOAD   8'h00
`define IBC_OFF_BUFFER   8'h04
`define IBC_OFF_CTRL1    8'h08
`define IBC_OFF_CTRL2    8'h0C
`define IBC_OFF_STATUS   8'h10
`define IBC_OFF_IRQ_EN   8'h14
`define IBC_OFF_IRQ_FLAG 8'h18

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define IBC_CTRL1_WCOL   7
`define IBC_CTRL1_EN     5
`define IBC_CTRL1_MODE_HI 3
`define IBC_CTRL2_STOP   2
`define IBC_STATUS_STOP  4
`define IBC_IRQ_PORT     4
`define IBC_IRQ_COLL     3

// ----------------------------------------------------------------------
// Reset values and mode codes
// ----------------------------------------------------------------------
`define IBC_RST_RELOAD   8'h4F
`define IBC_RST_BYTE     8'h00
`define IBC_MODE_I2C_MST 4'h8
`define IBC_MODE_SPI_BRG 4'hA

// ----------------------------------------------------------------------
// Timing: counter decrements every TICK_DIV clocks, so that one half
// period is (reload + 1) * 2 clocks and a full period 4 * (reload + 1)
// ----------------------------------------------------------------------
`define IBC_CLK_PERIOD_NS 4
`define IBC_TICK_DIV      2
`define IBC_HALF_PERIODS  5'h10

`endif

// [inc/ibc_pkg.sv]
/*
  Types for the two-wire master baud counter and stop collision block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ibc_pkg;
  // Stop sequence states, Gray coded from IDLE through DONE
  typedef enum logic [2:0] {
    IBC_ST_IDLE     = 3'b000,
    IBC_ST_SDA_LOW  = 3'b001,
    IBC_ST_SCL_REL  = 3'b011,
    IBC_ST_SCL_HIGH = 3'b010,
    IBC_ST_SDA_REL  = 3'b110,
    IBC_ST_DONE     = 3'b111
  } ibc_state_t;
endpackage

// [verilog/ibc_baud_counter.sv]
/*
  Reloadable down counter used as the serial clock time base.
  Assumes tick is a one-cycle enable from a divider in the parent.
*/
`timescale 1ns/1ps
module ibc_baud_counter #(
  parameter int WIDTH = 8
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             tick,          // Decrement enable
  input  wire logic             load,          // Reload strobe
  input  wire logic             run,           // Counting allowed
  input  wire logic [WIDTH-1:0] reload_value,
  output logic      [WIDTH-1:0] count,
  output logic                  expired        // Rollover pulse
);
  // ----------------------------------------------------------------------
  // Rollover detection
  // ----------------------------------------------------------------------
  // A rollover also reloads, so two rollovers make one clock period
  assign expired = run && tick && !load && (count == '0);

  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------
  // Holds its value while stopped so an idle port burns no toggles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (load || expired) begin
      count <= reload_value;
    end else if (run && tick) begin
      count <= count - 1'b1;
    end
  end
endmodule

// [verilog/ibc_stop_brg.sv]
/*
  Two-wire master baud counter and stop condition collision detection,
  with an APB register slave. Assumes open-drain pins resolved outside
  (oe_n low means the pin is pulled low) and inputs synchronous to pclk.
*/
`timescale 1ns/1ps
`include "ibc_consts.svh"
module ibc_stop_brg #(
  parameter int TICK_DIV = `IBC_TICK_DIV
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe_n,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  output logic             sck_out,
  output logic             collision_irq,
  output logic             port_irq
);
  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [7:0]         baud_reload_value;  // Counter reload
  logic [7:0]         shift_buffer;       // Last byte written outside a stop
  logic [7:0]         port_control_one;   // Enable, mode, write collision
  logic               stop_request;       // Stop sequence request
  logic               stop_seen;          // Stop observed on bus
  logic               collision_irq_enable;
  logic               port_irq_enable;
  logic               collision_flag;     // Sticky collision
  logic               port_irq_flag;      // Sticky port event
  ibc_pkg::ibc_state_t state;             // Stop sequence state
  logic [7:0]         baud_counter;       // Live counter value
  logic               brg_expired;        // Counter rollover
  logic               brg_load;           // Start-of-phase reload
  logic               brg_run;            // Counter running
  logic               tick;               // Decrement enable
  logic [$clog2(TICK_DIV+1)-1:0] tick_cnt;
  logic               gen_active;         // Free clocking active
  logic [4:0]         gen_halves;         // Half periods left
  logic               gen_start;          // Buffer write launch
  logic               apb_acc;            // Access phase, answer edge
  logic               wr_en;              // Write takes effect
  logic               port_on;
  logic               i2c_mode;
  logic               spi_mode;
  logic               stop_busy;
  logic               coll_event;         // Collision this cycle

  // Register address decode, used by read and write paths
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `IBC_OFF_RELOAD) || (a == `IBC_OFF_BUFFER) ||
             (a == `IBC_OFF_CTRL1)  || (a == `IBC_OFF_CTRL2)  ||
             (a == `IBC_OFF_STATUS) || (a == `IBC_OFF_IRQ_EN) ||
             (a == `IBC_OFF_IRQ_FLAG);
  endfunction

  assign apb_acc   = psel && penable && pready;
  assign wr_en     = apb_acc && pwrite && mapped(paddr);
  assign port_on   = port_control_one[`IBC_CTRL1_EN];
  assign i2c_mode  = port_control_one[`IBC_CTRL1_MODE_HI:0] ==
                     `IBC_MODE_I2C_MST;
  assign spi_mode  = port_control_one[`IBC_CTRL1_MODE_HI:0] ==
                     `IBC_MODE_SPI_BRG;
  assign stop_busy = state != ibc_pkg::IBC_ST_IDLE;
  assign gen_start = wr_en && (paddr == `IBC_OFF_BUFFER) && port_on &&
                     (i2c_mode || spi_mode) && !stop_busy;

  // ----------------------------------------------------------------------
  // APB slave: one wait state, answer registered
  // ----------------------------------------------------------------------
  // Ready rises one cycle into the access phase, so prdata is a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped(paddr);
      prdata  <= 32'h0000_0000;
      if (psel && penable && !pready && !pwrite) begin
        case (paddr)
          `IBC_OFF_RELOAD:  prdata[7:0] <= baud_reload_value;
          `IBC_OFF_BUFFER:  prdata[7:0] <= shift_buffer;
          `IBC_OFF_CTRL1:   prdata[7:0] <= port_control_one;
          `IBC_OFF_CTRL2:   prdata[`IBC_CTRL2_STOP] <= stop_request;
          `IBC_OFF_STATUS:  prdata[`IBC_STATUS_STOP] <= stop_seen;
          `IBC_OFF_IRQ_EN: begin
            prdata[`IBC_IRQ_COLL] <= collision_irq_enable;
            prdata[`IBC_IRQ_PORT] <= port_irq_enable;
          end
          `IBC_OFF_IRQ_FLAG: begin
            prdata[`IBC_IRQ_COLL] <= collision_flag;
            prdata[`IBC_IRQ_PORT] <= port_irq_flag;
          end
          default:          prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Plain software registers
  // ----------------------------------------------------------------------
  // Reload steers the counter; a buffer write during a stop is refused
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_reload_value    <= `IBC_RST_RELOAD;
      shift_buffer         <= `IBC_RST_BYTE;
      collision_irq_enable <= 1'b0;
      port_irq_enable      <= 1'b0;
    end else if (wr_en) begin
      if (paddr == `IBC_OFF_RELOAD) begin
        baud_reload_value <= pwdata[7:0];
      end
      if (paddr == `IBC_OFF_BUFFER && !stop_busy) begin
        shift_buffer <= pwdata[7:0];
      end
      if (paddr == `IBC_OFF_IRQ_EN) begin
        collision_irq_enable <= pwdata[`IBC_IRQ_COLL];
        port_irq_enable      <= pwdata[`IBC_IRQ_PORT];
      end
    end
  end

  // Control one; write collision set by a refused buffer write wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_control_one <= `IBC_RST_BYTE;
    end else begin
      if (wr_en && paddr == `IBC_OFF_CTRL1) begin
        port_control_one <= pwdata[7:0];
      end
      if (wr_en && paddr == `IBC_OFF_BUFFER && stop_busy) begin
        port_control_one[`IBC_CTRL1_WCOL] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Tick divider
  // ----------------------------------------------------------------------
  // Fixed step rate keeps the clock formula exact for any reload
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else begin
      tick <= (tick_cnt == '0);
      if (tick_cnt == '0) begin
        tick_cnt <= ($bits(tick_cnt))'(TICK_DIV - 1);
      end else begin
        tick_cnt <= tick_cnt - 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Baud counter
  // ----------------------------------------------------------------------
  // Runs only while a clocking job or a timed stop phase is live
  assign brg_load = gen_start ||
                    (state == ibc_pkg::IBC_ST_SCL_REL && scl_in);
  assign brg_run  = gen_active || state == ibc_pkg::IBC_ST_SCL_HIGH ||
                    state == ibc_pkg::IBC_ST_SDA_REL ||
                    state == ibc_pkg::IBC_ST_DONE;

  ibc_baud_counter #(
    .WIDTH (8)
  ) u_brg (
    .pclk         (pclk),
    .presetn      (presetn),
    .tick         (tick),
    .load         (brg_load),
    .run          (brg_run),
    .reload_value (baud_reload_value),
    .count        (baud_counter),
    .expired      (brg_expired)
  );

  // ----------------------------------------------------------------------
  // Free clocking after a buffer write
  // ----------------------------------------------------------------------
  // Eight periods; each rollover toggles the line, pin then holds
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_active <= 1'b0;
      gen_halves <= 5'h00;
    end else if (!port_on) begin
      gen_active <= 1'b0;
    end else if (gen_start) begin
      gen_active <= 1'b1;
      gen_halves <= `IBC_HALF_PERIODS;
    end else if (gen_active && brg_expired) begin
      gen_halves <= gen_halves - 1'b1;
      gen_active <= gen_halves != 5'h01;
    end
  end

  // SPI clock pin, toggled per rollover
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_out <= 1'b0;
    end else if (gen_active && brg_expired && spi_mode) begin
      sck_out <= !sck_out;
    end
  end

  // ----------------------------------------------------------------------
  // Stop sequence and collision checks
  // ----------------------------------------------------------------------
  always_comb begin
    coll_event = 1'b0;
    case (state)
      ibc_pkg::IBC_ST_SCL_HIGH: coll_event = !scl_in;
      ibc_pkg::IBC_ST_SDA_REL:
        coll_event = (!scl_in && !sda_in) ||
                     (brg_expired && !sda_in);
      default:                  coll_event = 1'b0;
    endcase
  end

  // Stop state machine; a collision drops straight back to idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ibc_pkg::IBC_ST_IDLE;
    end else if (!port_on || coll_event) begin
      state <= ibc_pkg::IBC_ST_IDLE;
    end else begin
      case (state)
        ibc_pkg::IBC_ST_IDLE:
          if (stop_request && i2c_mode && !gen_active) begin
            state <= ibc_pkg::IBC_ST_SDA_LOW;
          end
        ibc_pkg::IBC_ST_SDA_LOW:
          if (!sda_in) begin
            state <= ibc_pkg::IBC_ST_SCL_REL;
          end
        ibc_pkg::IBC_ST_SCL_REL:
          if (scl_in) begin
            state <= ibc_pkg::IBC_ST_SCL_HIGH;
          end
        ibc_pkg::IBC_ST_SCL_HIGH:
          if (brg_expired) begin
            state <= ibc_pkg::IBC_ST_SDA_REL;
          end
        ibc_pkg::IBC_ST_SDA_REL:
          if (brg_expired) begin
            state <= ibc_pkg::IBC_ST_DONE;
          end
        ibc_pkg::IBC_ST_DONE:
          if (brg_expired) begin
            state <= ibc_pkg::IBC_ST_IDLE;
          end
        default: state <= ibc_pkg::IBC_ST_IDLE;
      endcase
    end
  end

  // Open-drain drives; a stop request pulls SCL low together with SDA
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
      scl_out  <= 1'b0;
      sda_out  <= 1'b0;
    end else if (!port_on || coll_event) begin
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
    end else if (gen_active && brg_expired && i2c_mode) begin
      scl_oe_n <= !scl_oe_n;
    end else begin
      case (state)
        ibc_pkg::IBC_ST_IDLE:
          if (stop_request && i2c_mode && !gen_active) begin
            sda_oe_n <= 1'b0;
            scl_oe_n <= 1'b0;
          end
        ibc_pkg::IBC_ST_SDA_LOW:
          if (!sda_in) begin
            scl_oe_n <= 1'b1;
          end
        ibc_pkg::IBC_ST_SCL_HIGH:
          if (brg_expired) begin
            sda_oe_n <= 1'b1;
          end
        default: ;
      endcase
    end
  end

  // Stop request: software sets, hardware clears at the end or abort
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_request <= 1'b0;
    end else if (wr_en && paddr == `IBC_OFF_CTRL2 &&
                 pwdata[`IBC_CTRL2_STOP]) begin
      stop_request <= 1'b1;
    end else if (coll_event || !port_on) begin
      stop_request <= 1'b0;
    end else if (state == ibc_pkg::IBC_ST_DONE && brg_expired) begin
      stop_request <= 1'b0;
    end
  end

  // Stop seen status, set when SDA rises cleanly while SCL high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_seen <= 1'b0;
    end else if (!port_on) begin
      stop_seen <= 1'b0;
    end else if (state == ibc_pkg::IBC_ST_SDA_REL && brg_expired &&
                 !coll_event) begin
      stop_seen <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Flags and interrupt requests
  // ----------------------------------------------------------------------
  // Write one clears; a same-cycle hardware set wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      collision_flag <= 1'b0;
      port_irq_flag  <= 1'b0;
    end else begin
      if (coll_event) begin
        collision_flag <= 1'b1;
      end else if (wr_en && paddr == `IBC_OFF_IRQ_FLAG &&
                   pwdata[`IBC_IRQ_COLL]) begin
        collision_flag <= 1'b0;
      end
      if (state == ibc_pkg::IBC_ST_DONE && brg_expired) begin
        port_irq_flag <= 1'b1;
      end else if (wr_en && paddr == `IBC_OFF_IRQ_FLAG &&
                   pwdata[`IBC_IRQ_PORT]) begin
        port_irq_flag <= 1'b0;
      end
    end
  end

  // Requests lag the flags by one cycle, straight from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      collision_irq <= 1'b0;
      port_irq      <= 1'b0;
    end else begin
      collision_irq <= collision_flag && collision_irq_enable;
      port_irq      <= port_irq_flag && port_irq_enable;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  logic [11:0] exp_gap;   // Clocks since last rollover
  logic        exp_prev;  // A rollover was seen before
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exp_gap  <= 12'h000;
      exp_prev <= 1'b0;
    end else begin
      exp_gap  <= brg_expired ? 12'h001 : exp_gap + 12'h001;
      exp_prev <= gen_active && !brg_load && (exp_prev || brg_expired);
    end
  end

  sequence s_scl_released;
    state == ibc_pkg::IBC_ST_SDA_LOW && !sda_in;
  endsequence
  sequence s_lines_free;
    scl_oe_n && sda_oe_n && !stop_request;
  endsequence

  a_scl_after_sda: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(scl_oe_n) && stop_busy |-> !sda_oe_n && !$past(sda_in))
    else $error("SCL released before SDA sampled low");
  a_release_order: assert property (@(posedge pclk) disable iff (!presetn)
    (s_scl_released and port_on) |=> scl_oe_n && !sda_oe_n)
    else $error("SCL not released after SDA low");
  a_load_scl_high: assert property (@(posedge pclk) disable iff (!presetn)
    state == ibc_pkg::IBC_ST_SCL_REL && scl_in && port_on
    |=> baud_counter == $past(baud_reload_value))
    else $error("Counter not loaded on SCL high");
  a_coll_sda_low: assert property (@(posedge pclk) disable iff (!presetn)
    state == ibc_pkg::IBC_ST_SDA_REL && brg_expired && !sda_in
    |=> collision_flag && state == ibc_pkg::IBC_ST_IDLE)
    else $error("Missed collision on SDA low after expiry");
  a_coll_scl_low: assert property (@(posedge pclk) disable iff (!presetn)
    state == ibc_pkg::IBC_ST_SCL_HIGH && !scl_in |=> collision_flag)
    else $error("Missed collision on early SCL low");
  a_coll_release: assert property (@(posedge pclk) disable iff (!presetn)
    coll_event && !(wr_en && paddr == `IBC_OFF_CTRL2)
    |=> s_lines_free)
    else $error("Lines or request not cleared on collision");
  a_stop_complete: assert property (@(posedge pclk) disable iff (!presetn)
    state == ibc_pkg::IBC_ST_DONE && brg_expired && port_on
    && !(wr_en && paddr == `IBC_OFF_CTRL2)
    |=> !stop_request && port_irq_flag && stop_seen)
    else $error("Stop did not complete cleanly");
  a_buffer_launch: assert property (@(posedge pclk) disable iff (!presetn)
    gen_start |=> gen_active ##1 gen_active)
    else $error("Buffer write did not start counting");
  a_half_period: assert property (@(posedge pclk) disable iff (!presetn)
    brg_expired && exp_prev && $stable(baud_reload_value)
    |-> exp_gap == 12'(TICK_DIV) * (12'(baud_reload_value) + 12'h001))
    else $error("Half period length wrong");
  a_irq_gated: assert property (@(posedge pclk) disable iff (!presetn)
    !collision_irq_enable ##1 !collision_irq_enable |-> !collision_irq)
    else $error("Collision interrupt without enable");
endmodule

// [tb/ibc_bus_model.sv]
/* Open-drain two-wire bus with pull-ups and one rival master.
   Assumes the bench commands the rival's pull requests. */
`timescale 1ns/1ps
module ibc_bus_model (
  input  wire logic scl_oe_n,  // Our master pulls clock
  input  wire logic sda_oe_n,  // Our master pulls data
  input  wire logic hold_scl,  // Rival pulls clock
  input  wire logic hold_sda,  // Rival pulls data
  output logic      scl,
  output logic      sda
);
  // Wired AND; pull-up wins once all let go
  assign scl = scl_oe_n & ~hold_scl;
  assign sda = sda_oe_n & ~hold_sda;
endmodule

// [tb/test_i2c_master_brg_stop_collision.sv]
/* Bench for the baud counter and stop collision block.
   Assumes APB with one wait state and an open-drain bus model. */
`timescale 1ns/1ps
module test_i2c_master_brg_stop_collision;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0;
  logic        pwrite = 0, hold_scl = 0, hold_sda = 0, err;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, scl, sda, scl_oe_n, sda_oe_n;
  logic        sck_out, collision_irq, port_irq, scl_out, sda_out;
  int          fails = 0, n_compared = 0;
  localparam logic [7:0] N = 8'h03; // Lowest legal reload
  // Watched outputs, indexed by the wait tasks
  wire [4:0]   obs = {sck_out, sda_oe_n, scl_oe_n, collision_irq, port_irq};
  always #2 pclk = ~pclk;
  ibc_stop_brg u_ibc_stop_brg (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_in(scl), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .sck_out(sck_out),
    .collision_irq(collision_irq), .port_irq(port_irq));
  ibc_bus_model u_ibc_bus_model (.scl_oe_n(scl_oe_n),
    .sda_oe_n(sda_oe_n), .hold_scl(hold_scl), .hold_sda(hold_sda),
    .scl(scl), .sda(sda));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; holds the request until pready is sampled
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    chk(pready, 1'b1); // A missing answer counts as a mismatch
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    chk(rd, e);
  endtask
  // Bounded wait for a watched output to reach a level
  task wait_for(input int i, input logic v);
    int k;
    k = 0;
    @(negedge pclk);
    while (obs[i] !== v && k < 300) begin
      @(negedge pclk);
      k++;
    end
    chk(obs[i], v);
  endtask
  // Clocks between two toggles of a watched output
  task gap(input int i, input int e);
    int k;
    logic v;
    for (int s = 0; s < 2; s++) begin
      v = obs[i];
      k = 0;
      while (obs[i] === v && k < 300) begin
        @(negedge pclk);
        k++;
      end
    end
    chk(k, e);
  endtask
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    rdchk(8'h00, 32'h4F);
    apb(0, 8'h1C, 32'h0);
    chk({rd[0], err}, 2'b01);
    apb(1, 8'h00, {24'h0, N});
    apb(1, 8'h14, 32'h18);
    apb(1, 8'h08, 32'h28);
    apb(1, 8'h0C, 32'h04);
    wait_for(3, 0);
    wait_for(2, 1);
    apb(1, 8'h04, 32'h77);
    rdchk(8'h08, 32'hA8);
    rdchk(8'h04, 32'h0);
    wait_for(3, 1);
    wait_for(0, 1);
    rdchk(8'h10, 32'h10);
    rdchk(8'h0C, 32'h0);
    apb(1, 8'h18, 32'h10);
    hold_sda <= 1;
    apb(1, 8'h0C, 32'h04);
    wait_for(1, 1);
    rdchk(8'h0C, 32'h0);
    chk(obs[3:2], 2'b11);
    chk({scl_out, sda_out}, 2'b00);
    hold_sda <= 0;
    apb(1, 8'h18, 32'h08);
    wait_for(1, 0);
    apb(1, 8'h0C, 32'h04);
    wait_for(2, 0);
    wait_for(2, 1);
    @(posedge pclk);
    hold_scl <= 1;
    wait_for(1, 1);
    @(posedge pclk);
    hold_scl <= 0;
    rdchk(8'h18, 32'h08);
    apb(1, 8'h14, 32'h10);
    wait_for(1, 0);
    apb(1, 8'h18, 32'h08);
    apb(1, 8'h04, 32'hA5);
    gap(2, 2 * (N + 1));
    repeat (150) @(negedge pclk);
    rd = obs;
    chk(rd[2], 1'b1);
    gap(2, 300);
    chk(obs[2], rd[2]);
    apb(1, 8'h08, 32'h2A);
    apb(1, 8'h04, 32'h5A);
    gap(4, 2 * (N + 1));
    test_done;
  end
  // Watchdog well beyond the thousand or so cycles the tests need
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    test_done;
  end
endmodule
